// ### iosc_clock_select.sv
// Internal oscillator clock select: source, postscaler, 4x PLL, pin modes.
// Raw oscillators arrive as one-cycle ticks synchronous to sys_clk; the
// system clock leaves as a tick stream, the pins as value plus enable.
//
// Functional notes
// - High-freq postscaler spans 31 kHz to 16 MHz
// - Low range from high-freq osc: low=1, mid=0
// - Low=1, mid=1 selects mid-freq osc range
// - Low=0 selects low-freq RC, 31 kHz only
// - RC on when selected or timers need it
// - Reset restores 8 MHz selection
// - Select from postscaler, low and mid bits
// - Pin arrangement from nonvolatile config bits
// - Int clkout: out pin Fosc/4, in pin port bit7
// - Int pins io: both pins are port bits
// - PLL multiplies high-freq output by four
// - PLL enabled by software pll_on bit
// - PLL only with postscaler 111 or 110
// - PLL clkout: out pin Fosc/4, in pin bit7
// - PLL pins io: both pins are port bits
`timescale 1ns/1ns
module iosc_clock_select #(
  parameter int DIV_WIDTH = 9
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hfOscTick,
  input wire logic hfPllTick,
  input wire logic mfOscTick,
  input wire logic lfRcTick,
  input wire logic [7:0] oscControlWr,
  input wire logic oscControlWe,
  input wire logic [7:0] oscTuningWr,
  input wire logic oscTuningWe,
  input wire logic [7:0] oscControl2Wr,
  input wire logic oscControl2We,
  input wire logic [1:0] oscConfigField,
  input wire logic powerUpTimerOn,
  input wire logic failSafeMonOn,
  input wire logic watchdogOn,
  input wire logic twoSpeedOn,
  input wire logic portA6Out,
  input wire logic portA6Oe,
  input wire logic portA7Out,
  input wire logic portA7Oe,
  input wire logic oscInPinIn,
  input wire logic oscOutPinIn,
  output logic sysClkTick,
  output logic [2:0] postscalerSelect,
  output logic lowSourceSelect,
  output logic midOscSelect,
  output logic pllOn,
  output logic pllActive,
  output logic lowFreqRcEnable,
  output logic [1:0] activeSource,
  output logic oscOutPinOut,
  output logic oscOutPinOe,
  output logic oscInPinOut,
  output logic oscInPinOe,
  output logic portA6In,
  output logic portA7In
);

  iosc_pkg::iosc_src_t nextSource;
  iosc_pkg::iosc_pinmode_t pinMode;
  logic [3:0] nextShift;
  logic nextPll;
  logic srcTick;
  logic divTick;
  logic [1:0] quarterCount;
  logic clkoutMode;

  // ---------------------------------------------------------------
  // Control bits
  // ---------------------------------------------------------------
  // Software writes; any reset returns to the 8 MHz selection
  // Unused write bits are dropped; there is no read-back path here
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Code 110 with the 4x off is the 8 MHz default
      postscalerSelect <= iosc_pkg::PSEL_RESET;
      lowSourceSelect <= iosc_pkg::LOWSRC_RESET;
      midOscSelect <= iosc_pkg::MIDSEL_RESET;
      pllOn <= iosc_pkg::PLLON_RESET;
    end else begin
      if (oscControlWe) begin
        postscalerSelect <=
          oscControlWr[iosc_pkg::PSEL_MSB:iosc_pkg::PSEL_LSB];
      end
      if (oscTuningWe) begin
        lowSourceSelect <= oscTuningWr[iosc_pkg::LOWSRC_BIT];
        pllOn <= oscTuningWr[iosc_pkg::PLLON_BIT];
      end
      if (oscControl2We) begin
        midOscSelect <= oscControl2Wr[iosc_pkg::MIDSEL_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Source and postscaler decode
  // ---------------------------------------------------------------
  // Code 111 is the full high_freq_osc rate (16 MHz), each lower code down to 001
  // halves it, so 110 is 8 MHz and 000 lands at the low range.
  // At codes 100 and below the source depends on the low and mid bits.
  // Codes 101 to 001 step the high-freq path from 4 MHz to 250 kHz.
  // A shift change mid-count only stretches or shortens one output period.
  always_comb begin
    nextShift = 4'(3'h7 - postscalerSelect);
    nextSource = iosc_pkg::IOSC_SRC_HF;
    if (postscalerSelect == 3'h0) begin
      if (!lowSourceSelect) begin
        nextSource = iosc_pkg::IOSC_SRC_LF;
        nextShift = 4'h0;
      end else if (midOscSelect) begin
        // Lowest mid-osc step, 500 kHz / 16, keeps the codes descending
        nextSource = iosc_pkg::IOSC_SRC_MF;
        nextShift = 4'h4;
      end else begin
        nextShift = 4'h9;
      end
    end else if (postscalerSelect <= 3'h4 && lowSourceSelect &&
                 midOscSelect) begin
      // Mid osc runs at 500 kHz; codes 1..4 map 500 kHz down to 62.5 kHz
      nextSource = iosc_pkg::IOSC_SRC_MF;
      nextShift = 4'(3'h4 - postscalerSelect);
    end
    // The 4x only engages on the two top codes
    nextPll = pllOn && (postscalerSelect == iosc_pkg::PSEL_16MHZ ||
                        postscalerSelect == iosc_pkg::PSEL_8MHZ);
  end

  // Pick the raw tick stream; pll tick is the 4x high_freq_osc
  always_comb begin
    srcTick = 1'b0; // Keeps the mux free of latches
    unique case (nextSource)
      iosc_pkg::IOSC_SRC_HF: srcTick = nextPll ? hfPllTick : hfOscTick;
      iosc_pkg::IOSC_SRC_MF: srcTick = mfOscTick;
      iosc_pkg::IOSC_SRC_LF: srcTick = lfRcTick;
    endcase
  end

  // Same divide applies after the PLL, giving 64 or 32 MHz
  // Nine counter bits suffice: the longest divide is 512
  iosc_div #(
    .WIDTH(DIV_WIDTH)
  ) postscaler (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .inTick(srcTick),
    .shift(nextShift),
    .outTick(divTick)
  );

  // ---------------------------------------------------------------
  // Status and clock outputs
  // ---------------------------------------------------------------
  // Status lags the controls by one cycle, so every port is a flop
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sysClkTick <= 1'b0;
      pllActive <= 1'b0;
      activeSource <= 2'h0;
      lowFreqRcEnable <= 1'b0;
    end else begin
      sysClkTick <= divTick;
      pllActive <= nextPll;
      activeSource <= nextSource;
      // RC also kept alive for timers and monitors
      lowFreqRcEnable <= nextSource == iosc_pkg::IOSC_SRC_LF ||
        powerUpTimerOn || failSafeMonOn || watchdogOn ||
        twoSpeedOn;
    end
  end

  // ---------------------------------------------------------------
  // Pin arrangement
  // ---------------------------------------------------------------
  // Nonvolatile bits only, never runtime registers
  // Mode is taken as static; a change is not glitch-filtered on the pin
  assign pinMode = iosc_pkg::iosc_pinmode_t'(oscConfigField);
  assign clkoutMode = pinMode == iosc_pkg::IOSC_INT_CLKOUT ||
    pinMode == iosc_pkg::IOSC_PLL_CLKOUT;

  // Fosc/4: toggle every second system tick for a quarter-rate square
  // Counts only system ticks, so the pin follows any rate change
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      quarterCount <= 2'h0;
    end else if (divTick) begin
      quarterCount <= quarterCount + 2'h1;
    end
  end

  // Pins registered so outputs come from flops; one cycle of latency
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      oscOutPinOut <= 1'b0;
      oscOutPinOe <= 1'b0;
      oscInPinOut <= 1'b0;
      oscInPinOe <= 1'b0;
      portA6In <= 1'b0;
      portA7In <= 1'b0;
    end else begin
      oscInPinOut <= portA7Out;
      oscInPinOe <= portA7Oe;
      portA7In <= oscInPinIn;
      if (clkoutMode) begin
        oscOutPinOut <= quarterCount[1];
        oscOutPinOe <= 1'b1;
        // Bit6 reads 0 while its pin carries the clock
        portA6In <= 1'b0;
      end else begin
        oscOutPinOut <= portA6Out;
        oscOutPinOe <= portA6Oe;
        portA6In <= oscOutPinIn;
      end
    end
  end

endmodule

// ### iosc_pkg.sv
// Package for the internal oscillator clock select block.
// Assumes a single 100 MHz system clock domain; no bus, plain ports.
package iosc_pkg;

  // ---------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------
  localparam int PSEL_MSB = 6;
  localparam int PSEL_LSB = 4;
  localparam int LOWSRC_BIT = 7;
  localparam int PLLON_BIT = 6;
  localparam int MIDSEL_BIT = 0;

  // ---------------------------------------------------------------
  // Postscaler codes and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] PSEL_16MHZ = 3'h7;
  localparam logic [2:0] PSEL_8MHZ = 3'h6;
  localparam logic [2:0] PSEL_RESET = 3'h6;
  localparam logic LOWSRC_RESET = 1'h0;
  localparam logic MIDSEL_RESET = 1'h0;
  localparam logic PLLON_RESET = 1'h0;

  // Full-rate high_freq_osc divide ratio index for code 111 (log2)
  localparam logic [2:0] SHIFT_16MHZ = 3'h0;
  localparam int PLL_FACTOR = 4;
  localparam int OUT_DIV = 4;

  // Clock source choice
  typedef enum logic [1:0] {
    IOSC_SRC_HF,
    IOSC_SRC_MF,
    IOSC_SRC_LF
  } iosc_src_t;

  // Pin arrangement from nonvolatile configuration
  typedef enum logic [1:0] {
    IOSC_INT_CLKOUT,
    IOSC_INT_PINS_IO,
    IOSC_PLL_CLKOUT,
    IOSC_PLL_PINS_IO
  } iosc_pinmode_t;

endpackage

// ### iosc_div.sv
// Power-of-two divider producing a one-cycle tick per output period.
// Assumes the input tick stream is synchronous to sys_clk.
`timescale 1ns/1ns
module iosc_div #(
  parameter int WIDTH = 9
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic inTick,
  input wire logic [3:0] shift,
  output logic outTick
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] mask;

  // Terminal mask; a shift of zero passes every tick
  assign mask = WIDTH'((1 << shift) - 1);

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // Count input ticks, emit one at each wrap of the masked count
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      outTick <= 1'b0;
    end else begin
      outTick <= 1'b0;
      if (inTick) begin
        if ((count & mask) == mask) begin
          count <= '0;
          outTick <= 1'b1;
        end else begin
          count <= count + WIDTH'(1);
        end
      end
    end
  end

endmodule

// ### iosc_clock_select_monitor.sv
// Assertion checker for the internal oscillator clock select ports.
// Assumes one sys_clk domain; bound to every iosc_clock_select instance.
`timescale 1ns/1ns
module iosc_clock_select_monitor (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] oscControlWr,
  input wire logic oscControlWe,
  input wire logic [1:0] oscConfigField,
  input wire logic powerUpTimerOn,
  input wire logic failSafeMonOn,
  input wire logic watchdogOn,
  input wire logic twoSpeedOn,
  input wire logic portA6Out,
  input wire logic portA6Oe,
  input wire logic portA7Out,
  input wire logic portA7Oe,
  input wire logic oscInPinIn,
  input wire logic oscOutPinIn,
  input wire logic [2:0] postscalerSelect,
  input wire logic lowSourceSelect,
  input wire logic midOscSelect,
  input wire logic pllOn,
  input wire logic pllActive,
  input wire logic lowFreqRcEnable,
  input wire logic [1:0] activeSource,
  input wire logic oscOutPinOut,
  input wire logic oscOutPinOe,
  input wire logic oscInPinOut,
  input wire logic oscInPinOe,
  input wire logic portA6In,
  input wire logic portA7In
);
  // ----------------------------------------
  // Expected decode, from the current controls
  // ----------------------------------------
  logic ckMode;
  logic [1:0] srcExp;
  logic timersOn;
  assign ckMode = !oscConfigField[0];
  assign timersOn = powerUpTimerOn | failSafeMonOn | watchdogOn | twoSpeedOn;
  // Code 000 with the low bit clear is the only RC choice
  assign srcExp = (!lowSourceSelect && postscalerSelect == 3'h0) ? 2'h2 :
    (lowSourceSelect && midOscSelect && postscalerSelect <= 3'h4) ? 2'h1 :
    2'h0;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  rst_code_a: assert property (
    $rose(reset_n) |-> postscalerSelect == iosc_pkg::PSEL_RESET &&
    lowSourceSelect == iosc_pkg::LOWSRC_RESET && !pllOn && !pllActive)
    else $error("reset postscaler code wrong");
  psel_wr_a: assert property (
    oscControlWe |=> postscalerSelect == $past(oscControlWr[6:4]))
    else $error("code write");
  // Registered outputs still hold reset values at the first edge after
  // release, while the random inputs were live, so that edge is skipped
  pll_gate_a: assert property (
    $past(reset_n) |->
    pllActive == $past(pllOn && postscalerSelect[2:1] == 2'h3))
    else $error("pll gate");
  rc_enable_a: assert property (
    $past(reset_n) |-> lowFreqRcEnable == $past(timersOn || srcExp == 2'h2))
    else $error("rc enable wrong");
  src_sel_a: assert property (
    $past(reset_n) |-> activeSource == $past(srcExp))
    else $error("source decode wrong");
  out_oe_a: assert property (
    $past(reset_n) |-> oscOutPinOe == $past(ckMode || portA6Oe))
    else $error("out pin enable");
  a6_drive_a: assert property (
    $past(reset_n && !ckMode) |-> oscOutPinOut == $past(portA6Out))
    else $error("port bit6 drive");
  in_pin_a: assert property (
    $past(reset_n) |-> {oscInPinOe, oscInPinOut, portA7In} ==
    $past({portA7Oe, portA7Out, oscInPinIn}))
    else $error("in pin as port");
  a6_read_a: assert property (
    $past(reset_n) |-> portA6In == $past(!ckMode && oscOutPinIn))
    else $error("port bit6 read");
endmodule

bind iosc_clock_select iosc_clock_select_monitor monitor (.*);

// ### test_iosc_clock_select.sv
// Self-checking bench for iosc_clock_select with an in-bench model.
// Assumes the package, design and checker files are compiled first.
`timescale 1ns/1ns
module test_iosc_clock_select;
  logic sys_clk = '0, reset_n = '0, hfOscTick = '0, hfPllTick = '0;
  logic mfOscTick = '0, lfRcTick = '0, oscControlWe = '0, oscTuningWe = '0;
  logic oscControl2We = '0, powerUpTimerOn = '0, failSafeMonOn = '0;
  logic watchdogOn = '0, twoSpeedOn = '0, portA6Out = '0, portA6Oe = '0;
  logic portA7Out = '0, portA7Oe = '0, oscInPinIn = '0, oscOutPinIn = '0;
  logic [7:0] oscControlWr = '0, oscTuningWr = '0, oscControl2Wr = '0;
  logic [1:0] oscConfigField = '0, activeSource;
  logic [2:0] postscalerSelect;
  logic sysClkTick, lowSourceSelect, midOscSelect, pllOn, pllActive;
  logic lowFreqRcEnable, oscOutPinOut, oscOutPinOe, oscInPinOut;
  logic oscInPinOe, portA6In, portA7In, lastPin;
  logic [31:0] rnd = 32'h5FDDE6FB;
  int n_mismatch, samples_checked, cycles, cyc, nOut, nTog, eSrc, eDiv, eAct;
  int srcCnt [4];
  int cfg [11][4] = '{'{7, 0, 0, 0}, '{7, 0, 0, 1}, '{6, 0, 0, 1},
    '{5, 0, 0, 1}, '{0, 0, 0, 0}, '{0, 1, 0, 0}, '{0, 1, 1, 0},
    '{2, 1, 1, 0}, '{3, 0, 1, 0}, '{4, 1, 1, 0}, '{1, 1, 0, 0}};

  iosc_clock_select dut (.*);

  always #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Oscillators as tick trains; pins and timers random, timers mostly off
  always @(negedge sys_clk) begin
    cyc++;
    hfOscTick = cyc % 4 == 0;
    hfPllTick = 1'h1;
    mfOscTick = cyc % 16 == 0;
    lfRcTick = cyc % 64 == 0;
    rnd = lfsr(rnd);
    {powerUpTimerOn, failSafeMonOn, watchdogOn, twoSpeedOn} =
      rnd[3:0] & rnd[7:4] & rnd[11:8];
    {portA6Out, portA6Oe, portA7Out, portA7Oe} = rnd[15:12];
    {oscInPinIn, oscOutPinIn} = rnd[17:16];
  end

  // Tallies over the window; the cycle ceiling cuts a hang short
  always @(posedge sys_clk) begin
    foreach (srcCnt[i]) srcCnt[i] += {hfOscTick, hfPllTick, mfOscTick,
      lfRcTick} >> (3 - i) & 1;
    nOut += sysClkTick;
    nTog += oscOutPinOut !== lastPin;
    lastPin = oscOutPinOut;
    if (++cycles == 80000) begin
      n_mismatch++;
      give_verdict;
    end
  end

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  // Source index (hf, pll, mf, lf), divide ratio and reported source
  task automatic model(int c, int lo, int mi, int pl);
    eAct = 0;
    eSrc = 0;
    eDiv = 1 << (7 - c);
    if (pl && c >= 6) eSrc = 1;
    else if (c == 0 && !lo) begin
      {eAct, eSrc, eDiv} = {32'h2, 32'h3, 32'h1};
    end else if (lo && mi && c <= 4) begin
      {eAct, eSrc, eDiv} = {32'h1, 32'h2, 32'(1 << (4 - c))};
    end else if (c == 0) eDiv = 512;
  endtask

  // Settle, then count output ticks against the selected source
  task automatic measure(int c, int lo, int mi, int pl);
    model(c, lo, mi, pl);
    repeat (20) @(negedge sys_clk);
    srcCnt = '{4{0}};
    {nOut, nTog} = '0;
    repeat (4096) @(negedge sys_clk);
    check(postscalerSelect, 32'(c));
    check({lowSourceSelect, midOscSelect, pllOn}, {lo[0], mi[0], pl[0]});
    check(activeSource, eAct);
    check(pllActive, 32'(pl && c >= 6));
    check(32'((nOut - srcCnt[eSrc] / eDiv) inside {[-1:1]}), 32'h1);
    if (!oscConfigField[0])
      check(32'((nTog - nOut / 2) inside {[-1:1]}), 32'h1);
  endtask

  // All three control writes at once; unused bits carry noise
  task automatic setup(int c, int lo, int mi, int pl, int m);
    @(negedge sys_clk);
    oscControlWr = {rnd[31], c[2:0], rnd[27:24]};
    oscTuningWr = {lo[0], pl[0], rnd[21:16]};
    oscControl2Wr = {rnd[14:8], mi[0]};
    oscConfigField = 2'(m);
    {oscControlWe, oscTuningWe, oscControl2We} = 3'h7;
    @(negedge sys_clk);
    {oscControlWe, oscTuningWe, oscControl2We} = 3'h0;
    measure(c, lo, mi, pl);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Reset, table of awkward settings, random ones, reset mid-run
  initial begin
    repeat (4) @(negedge sys_clk);
    reset_n = 1'h1;
    measure(6, 0, 0, 0);
    foreach (cfg[i]) setup(cfg[i][0], cfg[i][1], cfg[i][2], cfg[i][3], i);
    // Random settings ask for the 4x only on the two top codes
    repeat (3) setup(rnd[2:0], rnd[3], rnd[4], rnd[5] & rnd[2] & rnd[1],
      rnd[7:6]);
    reset_n = 1'h0;
    @(negedge sys_clk);
    reset_n = 1'h1;
    measure(6, 0, 0, 0);
    give_verdict;
  end
endmodule
